/* File: dio48_pkg.sv */
`default_nettype none
package dio48_pkg;
    localparam int NPORT = 6;                       // byte ports
    localparam int NEVT  = 24;                      // event channels
    localparam int NGRP  = 3;                       // event byte groups
    // register indices, byte address is four times the index
    localparam logic [4:0] IDX_PORT0   = 5'h00;
    localparam logic [4:0] IDX_PORT5   = 5'h05;
    localparam logic [4:0] IDX_PENDSUM = 5'h06;
    localparam logic [4:0] IDX_PAGE    = 5'h07;
    localparam logic [4:0] IDX_GRP0    = 5'h08;
    localparam logic [4:0] IDX_GRP2    = 5'h0A;
    // page/lock field positions
    localparam int PAGE_LSB = 6;
    localparam int LOCK_W   = 6;
    // page numbers for the upper offsets
    localparam logic [1:0] PG_NONE = 2'h0;
    localparam logic [1:0] PG_POL  = 2'h1;
    localparam logic [1:0] PG_ENAB = 2'h2;
    localparam logic [1:0] PG_PEND = 2'h3;
    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [1:0]  RST_PAGE  = 2'h0;
    localparam logic [5:0]  RST_LOCK  = 6'h00;
    localparam logic [23:0] RST_EVT   = 24'h000000;
    localparam logic [31:0] RST_RDATA = 32'h00000000;
    // window of 32 addresses spans two 16-address blocks
    localparam logic [11:0] WIN_BLOCKS = 12'h002;
    localparam int          IO_ADDR_LSB = 2;

    // bus slave states
    typedef enum logic [0:0] {BS_IDLE, BS_RDWAIT} dio48_bus_st_t;

    // request held over into the data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       hit;
        logic [4:0] off;
    } dio48_dphase_t;
endpackage
`default_nettype wire

/* File: dio48_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pins that come from outside the clock domain
module dio48_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;   // metastable stage, read only by stage two

    // first stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= '0;
        end else begin
            stage1 <= din;
        end
    end

    // second stage, safe for logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dout <= '0;
        end else begin
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: dio48_port.sv */
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// 48-channel open-drain port with edge event sensing on channels 0 to 23, AHB-Lite register access
module dio48_port (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [47:0] dio_in,
    output logic      [47:0] dio_out,
    output logic      [47:0] dio_oe,
    input  wire logic [11:0] base_address_jumpers,
    input  wire logic [3:0]  irq_route_jumpers,
    output logic      [15:0] irq_lines
);
    logic [47:0]           pin_s;              // synchronised pin levels
    logic [11:0]           base_s;             // synchronised base jumpers
    logic [3:0]            route_s;            // synchronised route jumpers
    logic [7:0]            port_latch [6];     // output latches
    logic [5:0]            lock;               // write-protect mask
    logic [1:0]            page;               // page select
    logic [23:0]           pol;                // edge polarity
    logic [23:0]           enab;               // event enables
    logic [23:0]           edge_pending_flags; // sticky event flags
    logic [23:0]           pin_prev;           // last level for edge detect
    logic [23:0]           hit;                // edge of chosen direction
    logic [2:0]            clr_grp;            // group clear strobes
    dio48_pkg::dio48_bus_st_t bus_st;          // slave state
    dio48_pkg::dio48_dphase_t dp;              // data-phase request
    logic                  accept;             // address phase taken
    logic [15:0]           io_addr;            // word index as io address
    logic [11:0]           blk_diff;           // block distance from base
    logic                  wr_en;              // write lands this cycle
    logic [7:0]            wbyte;              // written byte
    logic [7:0]            grp_sel;            // selected event register
    logic [31:0]           next_rdata;         // read mux result
    logic                  irq_req;            // any flag pending

    // pins and jumpers come from outside, two flops before any use
    dio48_sync #(.W(48)) u_pin_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (dio_in),
        .dout    (pin_s)
    );
    dio48_sync #(.W(16)) u_jmp_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     ({irq_route_jumpers, base_address_jumpers}),
        .dout    ({route_s, base_s})
    );

    // address decode: io address is the word index; window is two blocks of 16
    assign io_addr  = haddr[dio48_pkg::IO_ADDR_LSB+:16];
    assign blk_diff = io_addr[15:4] - base_s;
    assign accept   = hsel && htrans[1] && hready;
    // any size is taken; data always sits in the low byte
    assign wr_en    = dp.valid && dp.write && dp.hit;
    assign wbyte    = hwdata[7:0];

    // capture the address phase whenever the bus moves on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= '0;
        end else if (hready) begin
            dp.valid <= accept;
            dp.write <= hwrite;
            dp.hit   <= (blk_diff < dio48_pkg::WIN_BLOCKS);
            dp.off   <= io_addr[4:0] - {base_s[0], 4'h0};
        end
    end

    // reads take one wait state so the mux sees a write just before it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st    <= dio48_pkg::BS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= dio48_pkg::RST_RDATA;
        end else begin
            case (bus_st)
                dio48_pkg::BS_IDLE: begin
                    if (accept && !hwrite) begin
                        bus_st    <= dio48_pkg::BS_RDWAIT;
                        hreadyout <= 1'b0;
                    end
                end
                dio48_pkg::BS_RDWAIT: begin
                    bus_st    <= dio48_pkg::BS_IDLE;
                    hreadyout <= 1'b1;
                    hrdata    <= next_rdata;
                end
                default: begin
                    bus_st    <= dio48_pkg::BS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // response is always okay; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // event register of the current page for a 08..0A offset
    always_comb begin
        grp_sel = dio48_pkg::RST_BYTE;
        if (dp.off >= dio48_pkg::IDX_GRP0 && dp.off <= dio48_pkg::IDX_GRP2) begin
            case (page)
                dio48_pkg::PG_POL:  grp_sel = pol[8*(dp.off[1:0])+:8];
                dio48_pkg::PG_ENAB: grp_sel = enab[8*(dp.off[1:0])+:8];
                dio48_pkg::PG_PEND: grp_sel = edge_pending_flags[8*(dp.off[1:0])+:8];
                default:            grp_sel = dio48_pkg::RST_BYTE;
            endcase
        end
    end

    // read mux; ports read the inverted pin, which shows the latch when driven
    always_comb begin
        next_rdata = dio48_pkg::RST_RDATA;
        if (dp.hit) begin
            if (dp.off <= dio48_pkg::IDX_PORT5) begin
                next_rdata[7:0] = ~pin_s[8*(dp.off[2:0])+:8];
            end else if (dp.off == dio48_pkg::IDX_PENDSUM) begin
                next_rdata[7:0] = {5'h00, |edge_pending_flags[23:16],
                                   |edge_pending_flags[15:8], |edge_pending_flags[7:0]};
            end else if (dp.off == dio48_pkg::IDX_PAGE) begin
                next_rdata[7:0] = {page, lock};
            end else begin
                next_rdata[7:0] = grp_sel;
            end
        end
    end

    // page and lock share one register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            page <= dio48_pkg::RST_PAGE;
            lock <= dio48_pkg::RST_LOCK;
        end else if (wr_en && dp.off == dio48_pkg::IDX_PAGE) begin
            page <= wbyte[dio48_pkg::PAGE_LSB+:2];
            lock <= wbyte[dio48_pkg::LOCK_W-1:0];
        end
    end

    // polarity and enables, one byte per group on their page
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pol  <= dio48_pkg::RST_EVT;
            enab <= dio48_pkg::RST_EVT;
        end else if (wr_en && dp.off >= dio48_pkg::IDX_GRP0 && dp.off <= dio48_pkg::IDX_GRP2) begin
            if (page == dio48_pkg::PG_POL) begin
                pol[8*(dp.off[1:0])+:8] <= wbyte;
            end
            if (page == dio48_pkg::PG_ENAB) begin
                enab[8*(dp.off[1:0])+:8] <= wbyte;
            end
        end
    end

    // any write on the pending page clears that whole group
    always_comb begin
        clr_grp = 3'h0;
        if (wr_en && page == dio48_pkg::PG_PEND && dp.off >= dio48_pkg::IDX_GRP0
            && dp.off <= dio48_pkg::IDX_GRP2) begin
            clr_grp[dp.off[1:0]] = 1'b1;
        end
    end

    // per-port latches; a locked port ignores writes
    genvar gp;
    generate
        for (gp = 0; gp < dio48_pkg::NPORT; gp++) begin : g_port
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    port_latch[gp] <= dio48_pkg::RST_BYTE;
                end else if (wr_en && dp.off == 5'(gp) && !lock[gp]) begin
                    port_latch[gp] <= wbyte;
                end
            end
            // a 1 sinks the pin, a 0 releases it; input use needs a 0 here
            assign dio_oe[8*gp+:8] = port_latch[gp];
        end
    endgenerate

    // open drain: the driven level is always low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dio_out <= '0;
        end else begin
            dio_out <= '0;
        end
    end

    // previous levels of the event pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev <= dio48_pkg::RST_EVT;
        end else begin
            pin_prev <= pin_s[23:0];
        end
    end

    // per-bit edge detect and sticky flag; a new edge beats a clear
    genvar gb;
    generate
        for (gb = 0; gb < dio48_pkg::NEVT; gb++) begin : g_evt
            assign hit[gb] = enab[gb] && (pol[gb] ? (pin_s[gb] && !pin_prev[gb])
                                                  : (!pin_s[gb] && pin_prev[gb]));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    edge_pending_flags[gb] <= 1'b0;
                end else if (!enab[gb]) begin
                    edge_pending_flags[gb] <= 1'b0;
                end else if (hit[gb]) begin
                    edge_pending_flags[gb] <= 1'b1;
                end else if (clr_grp[gb/8]) begin
                    edge_pending_flags[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq_req = |edge_pending_flags;

    // single request steered onto the jumpered line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_lines <= 16'h0000;
        end else begin
            irq_lines <= irq_req ? (16'h0001 << route_s) : 16'h0000;
        end
    end

    // a set lock bit must freeze its port latch
    a_lock_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en && dp.off == 5'h00 && lock[0] |=> $stable(port_latch[0]))
        else $error("locked port was written");

    // port reads show the synchronised pin, inverted
    a_port_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_st == dio48_pkg::BS_RDWAIT && dp.hit && dp.off == 5'h00
        |=> hrdata[7:0] == ~$past(pin_s[7:0]))
        else $error("port read is not the inverted pin");

    // a flag stays up until the host clears it
    a_pend_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_pending_flags[0] && enab[0] && !clr_grp[0] |=> edge_pending_flags[0])
        else $error("pending flag lost without a clear");

    // rising polarity records a low to high step
    a_rise_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        enab[0] && pol[0] && pin_s[0] && !pin_prev[0] |=> edge_pending_flags[0])
        else $error("rising edge not recorded");

    // a write on the pending page empties the group
    a_clear_group: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_grp[1] && hit[15:8] == 8'h00 |=> edge_pending_flags[15:8] == 8'h00)
        else $error("pending group not cleared");

    // the request lands on the jumpered line only
    a_irq_routed: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_req |=> irq_lines == (16'h0001 << $past(route_s)))
        else $error("interrupt not on routed line");

    // no pending flag means every line is quiet
    a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        !irq_req |=> irq_lines == 16'h0000)
        else $error("interrupt with nothing pending");

    // disabling a channel drops its pending flag
    a_disable_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        !enab[5] |=> !edge_pending_flags[5])
        else $error("disabled channel still pending");

    // every read costs exactly one wait state
    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    // rule checks below watch state that this module drives, plus the bus input hwrite in a_write_no_wait
    a_set_beats_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        hit[0] && clr_grp[0] |=> edge_pending_flags[0])
        else $error("edge lost to a group clear");

    // falling polarity records a high to low step
    a_fall_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        enab[1] && !pol[1] && !pin_s[1] && pin_prev[1] |=> edge_pending_flags[1])
        else $error("falling edge not recorded");

    // only an edge may raise a flag that was clear
    a_flag_needs_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        !edge_pending_flags[1] && !hit[1] |=> !edge_pending_flags[1])
        else $error("flag set without an edge");

    // a port latch changes only through a write to it
    a_latch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr_en && dp.off == 5'h02) |=> $stable(port_latch[2]))
        else $error("port latch changed without a write");

    // an unlocked write lands the low data byte
    a_latch_loads: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en && dp.off == 5'h05 && !lock[5] |=> port_latch[5] == $past(wbyte))
        else $error("port write did not land");

    // page and lock follow a write to their register
    a_page_loads: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en && dp.off == dio48_pkg::IDX_PAGE |=> {page, lock} == $past(wbyte))
        else $error("page and lock not loaded");

    // polarity bytes change only on their own page
    a_pol_page: assert property (@(posedge hclk) disable iff (!hresetn)
        page != dio48_pkg::PG_POL |=> $stable(pol))
        else $error("polarity changed off its page");

    // writes complete with no wait state
    a_write_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && hwrite && hreadyout |=> hreadyout)
        else $error("write was stalled");

    // requests outside the window touch no register
    a_window_miss: assert property (@(posedge hclk) disable iff (!hresetn)
        dp.valid && dp.write && !dp.hit |=> $stable(port_latch[0]) && $stable(lock))
        else $error("write outside the window landed");

    // the summary bit of group zero is the or of its flags
    a_summary_read: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_st == dio48_pkg::BS_RDWAIT && dp.hit && dp.off == dio48_pkg::IDX_PENDSUM |=> hrdata[0] == $past(|edge_pending_flags[7:0]))
        else $error("pending summary wrong");
endmodule
`default_nettype wire

/* File: dio48_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// field side of the 48 open-drain pins: pull-ups plus outside devices that may sink a line
module dio48_pins (
    input  wire logic [47:0] dio_out,
    input  wire logic [47:0] dio_oe,
    input  wire logic [47:0] ext_low,
    output logic      [47:0] dio_in
);
    // wired-and: any party sinking wins, otherwise the pull-up gives a high level
    // a driver that is not enabled leaves the line to the pull-up, never to its last value
    always_comb begin
        for (int i = 0; i < 48; i++) begin
            dio_in[i] = ((dio_oe[i] && !dio_out[i]) || ext_low[i]) ? 1'b0 : 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] BASE_B = 32'h0000_0800; // io base 200 hex, four bytes per io address
    localparam logic [15:0] IRQ_HOT = 16'h0400;     // line ten, chosen by the route jumpers
    logic        hclk;        // bus clock
    logic        hresetn;     // bus reset, active low
    logic        hsel;        // slave select
    logic [31:0] haddr;       // byte address
    logic [1:0]  htrans;      // transfer type
    logic        hwrite;      // write strobe
    logic [2:0]  hsize;       // transfer size
    logic [31:0] hwdata;      // write data
    logic        hreadyout;   // slave ready, also the bus ready
    logic        hresp;       // response, checked for okay on reads
    logic [31:0] hrdata;      // read data
    logic [47:0] dio_in;      // resolved pin levels
    logic [47:0] dio_out;     // drive value from the port
    logic [47:0] dio_oe;      // sink enables from the port
    logic [47:0] ext_low;     // outside devices sinking lines
    logic [15:0] irq_lines;   // routed interrupt request
    logic [11:0] jmp_base;    // base jumpers, 020 hex gives io base 200 hex
    logic [3:0]  jmp_route;   // route jumpers, binary line number
    int          err_count;   // mismatches
    int          compares;    // comparisons made

    dio48_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
        .base_address_jumpers(jmp_base), .irq_route_jumpers(jmp_route), .irq_lines(irq_lines));
    dio48_pins pins_u (.dio_out(dio_out), .dio_oe(dio_oe), .ext_low(ext_low), .dio_in(dio_in));

    // free-running bus clock, 5 ns period
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single transfer; entered just after a rising edge, waits on ready as long as it takes,
    // only the watchdog ends a hang
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hsize  <= sz;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, BASE_B + {25'h0, idx, 2'h0}, {24'h0, d}, 3'h2, r);
    endtask

    task automatic rchk(input string what, input logic [4:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, BASE_B + {25'h0, idx, 2'h0}, 32'h0, 3'h2, r);
        check(what, r, exp);
        check("okay response", {31'h0, hresp}, 32'h0);
    endtask

    // pin edges need two synchroniser stages, the flag stage and the irq stage
    task automatic settle;
        repeat (6) @(posedge hclk);
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask

    // a hang in the handshake ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        end_sim();
    end

    initial begin
        logic [31:0] r;
        {hsel, hwrite, htrans, haddr, hsize, hwdata, ext_low} = '0;
        jmp_base = 12'h020;
        jmp_route = 4'hA;
        err_count = 0;
        compares = 0;
        do_reset();
        check("sink enables after reset", {16'h0, dio_oe[15:0]}, 32'h0);
        for (int p = 0; p < 6; p++) rchk("port idle", p[4:0], 32'h0);
        for (int p = 0; p < 6; p++) wr(p[4:0], 8'(8'h11 * (p + 1)));
        for (int p = 0; p < 6; p++) begin
            rchk("port read back", p[4:0], 32'h11 * (p + 1));
            check("port sink enables", {24'h0, dio_oe[8*p +: 8]}, 32'h11 * (p + 1));
        end
        // narrow transfers: only the low byte lands
        xfer(1'b1, BASE_B + 32'h8, 32'h0000_BE3C, 3'h1, r);
        xfer(1'b1, BASE_B + 32'hC, 32'h0000_00C3, 3'h0, r);
        rchk("halfword write", 5'h02, 32'h3C);
        rchk("byte write", 5'h03, 32'hC3);
        // lock port 1, a write there must be dropped
        wr(5'h07, 8'h02);
        rchk("page lock reg", 5'h07, 32'h02);
        wr(5'h01, 8'hFF);
        rchk("locked port", 5'h01, 32'h22);
        wr(5'h07, 8'h00);
        // host releases every line before using it as input
        for (int p = 0; p < 6; p++) wr(p[4:0], 8'h00);
        ext_low[27] <= 1'b1;
        settle();
        rchk("input pin level", 5'h03, 32'h08);
        ext_low[27] <= 1'b0;
        // outside the window nothing decodes
        xfer(1'b1, BASE_B - 32'h40, 32'hFF, 3'h2, r);
        rchk("port after foreign write", 5'h00, 32'h0);
        rchk("window top", 5'h1F, 32'h0);
        xfer(1'b0, BASE_B + 32'h80, 32'h0, 3'h2, r);
        check("above window", r, 32'h0);
        // bit 0 rising, bit 1 falling, bit 2 not enabled
        wr(5'h07, 8'h40);
        wr(5'h08, 8'h01);
        rchk("polarity reg", 5'h08, 32'h01);
        wr(5'h07, 8'h80);
        wr(5'h08, 8'h03);
        rchk("enable reg", 5'h08, 32'h03);
        // page zero leaves the group registers dead: the write must not reach the enables
        wr(5'h07, 8'h00);
        wr(5'h08, 8'hFF);
        rchk("page zero group", 5'h08, 32'h0);
        wr(5'h07, 8'hC0);
        ext_low <= 48'h0000_0100_0007; // pins 0 to 2 low, and pin 24 on a port without events
        settle();
        rchk("falling edges", 5'h08, 32'h02);
        check("irq asserted", {16'h0, irq_lines}, {16'h0, IRQ_HOT});
        rchk("pending summary", 5'h06, 32'h01);
        ext_low <= '0;
        settle();
        rchk("rising edge, sticky", 5'h08, 32'h03);
        rchk("upper ports no events", 5'h06, 32'h01);
        wr(5'h08, 8'h5A);
        rchk("pending after clear", 5'h08, 32'h0);
        check("irq released", {16'h0, irq_lines}, 32'h0);
        // one-cycle pulse must still be latched
        ext_low[1] <= 1'b1;
        @(posedge hclk);
        ext_low[1] <= 1'b0;
        settle();
        rchk("short pulse", 5'h08, 32'h02);
        // re-jumper the request onto line three while a flag is pending
        jmp_route <= 4'h3;
        settle();
        check("irq rerouted", {16'h0, irq_lines}, 32'h0000_0008);
        jmp_route <= 4'hA;
        wr(5'h07, 8'h80);
        wr(5'h08, 8'h01);
        wr(5'h07, 8'hC0);
        rchk("pending after disable", 5'h08, 32'h0);
        // reset in mid-run clears latches and page/lock
        wr(5'h07, 8'h08);
        wr(5'h04, 8'h5A);
        do_reset();
        rchk("port after reset", 5'h04, 32'h0);
        rchk("page lock after reset", 5'h07, 32'h0);
        check("sink enables after reset", {16'h0, dio_oe[47:32]}, 32'h0);
        check("drive level", {16'h0, dio_out[47:32]} | dio_out[31:0], 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
